// file: hdl/irr_pkg.sv
// Package for the infrared remote carrier transmit/receive unit
package irr_pkg;
    // Register offsets (byte addresses)
    localparam logic [15:0] ADDR_CONFIG       = 16'h5340;
    localparam logic [15:0] ADDR_CARRIER      = 16'h5342;
    localparam logic [15:0] ADDR_LENGTH       = 16'h5344;
    localparam logic [15:0] ADDR_INTERRUPT    = 16'h5346;
    // Config field positions
    localparam int CFG_CAR_DIV_LSB  = 12;
    localparam int CFG_LEN_DIV_LSB  = 8;
    localparam int CFG_DIR_BIT      = 1;
    localparam int CFG_EN_BIT       = 0;
    // Carrier field positions
    localparam int CAR_LOW_LSB      = 8;
    localparam int CAR_HIGH_LSB     = 0;
    // Length counter field positions
    localparam int LEN_COUNT_LSB    = 8;
    localparam int LEN_LEVEL_BIT    = 0;
    // Interrupt control field positions
    localparam int INT_FALL_FLAG    = 10;
    localparam int INT_RISE_FLAG    = 9;
    localparam int INT_UFL_FLAG     = 8;
    localparam int INT_FALL_EN      = 2;
    localparam int INT_RISE_EN      = 1;
    localparam int INT_UFL_EN       = 0;
    // Reset values, reserved divider code and prescaler width
    localparam logic [3:0] DIV_RESET     = 4'h0;
    localparam logic [5:0] PHASE_RESET   = 6'h00;
    localparam logic [7:0] COUNT_RESET   = 8'h00;
    localparam logic [3:0] DIV_RESERVED  = 4'hF;
    localparam int         PRESCALE_BITS = 14;

    typedef enum logic {
        IRR_DIR_TX,
        IRR_DIR_RX
    } irr_dir_t;

    typedef struct packed {
        logic [3:0] car_div;
        logic [3:0] len_div;
        irr_dir_t   dir;
        logic       enable;
    } irr_cfg_t;

    typedef struct packed {
        logic fall;
        logic rise;
        logic ufl;
    } irr_cause_t;
endpackage

// file: hdl/irr_unit.sv
// Infrared remote carrier transmit/receive unit
`timescale 1ns/100ps
module irr_unit (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Register port
    input  wire logic [15:0] addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    // Infrared pins and interrupt
    input  wire logic        ir_input_pin,
    output logic             ir_output_pin,
    output logic             irq
);
    irr_pkg::irr_cfg_t   cfg;
    logic [5:0]          carrier_low_len;
    logic [5:0]          carrier_high_len;
    logic [7:0]          pulse_length_count;
    logic                pulse_level_bit;
    irr_pkg::irr_cause_t flags;
    irr_pkg::irr_cause_t irq_en;
    logic [13:0]         prescale;
    logic [13:0]         prescale_q;
    logic                car_tick;
    logic                len_tick;
    logic [2:0]          pin_sync;
    logic                pin_level;
    logic [1:0]          samp;
    logic                rx_level;
    logic                rise_evt;
    logic                fall_evt;
    logic                ufl_evt;
    logic [5:0]          phase_cnt;
    logic                carrier;
    logic                active;
    logic                tx_mode;
    logic                rx_mode;
    logic                count_run;

    // Tick when all divider bits below the code were ones; code 0 ticks always, code F never
    function automatic logic div_tick(input logic [13:0] pre,
                                      input logic [3:0]  code);
        logic [13:0] mask;
        mask = 14'h0000;
        if (code == irr_pkg::DIV_RESERVED) begin
            div_tick = 1'b0;
        end else begin
            mask = 14'(({15'h0000, 1'b1} << code) - 16'h0001);
            div_tick = ((pre & mask) == mask);
        end
    endfunction

    assign active  = cfg.enable;
    assign tx_mode = active && (cfg.dir == irr_pkg::IRR_DIR_TX);
    assign rx_mode = active && (cfg.dir == irr_pkg::IRR_DIR_RX);
    assign car_tick = div_tick(prescale, cfg.car_div);
    assign len_tick = div_tick(prescale, cfg.len_div);
    assign prescale_q = prescale;

    // Shared prescaler, held cleared while stopped so ticks restart cleanly
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prescale <= 14'h0000;
        end else if (!active) begin
            prescale <= 14'h0000;
        end else begin
            prescale <= prescale_q + 14'h0001;
        end
    end

    // Three-stage pin synchroniser
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_sync <= 3'b000;
        end else begin
            pin_sync <= {pin_sync[1:0], ir_input_pin};
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_level <= 1'b0;
        end else if (pin_sync[1] == pin_sync[2]) begin
            pin_level <= pin_sync[2];
        end
    end

    // Carrier-clock sampling; two equal samples filter out glitches
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            samp     <= 2'b00;
            rx_level <= 1'b0;
        end else if (!rx_mode) begin
            samp     <= {pin_level, pin_level};
            rx_level <= pin_level;
        end else if (car_tick) begin
            samp <= {samp[0], pin_level};
            if (samp[0] == pin_level && samp[1] != pin_level) begin
                rx_level <= pin_level;
            end
        end
    end

    assign rise_evt = rx_mode && car_tick && pin_level && samp[0]
                      && !samp[1] && !rx_level;
    assign fall_evt = rx_mode && car_tick && !pin_level && !samp[0]
                      && samp[1] && rx_level;

    // Carrier generator: high phase then low phase
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_cnt <= 6'h00;
            carrier   <= 1'b1;
        end else if (!tx_mode) begin
            phase_cnt <= 6'h00;
            carrier   <= 1'b1;
        end else if (car_tick) begin
            if (carrier && phase_cnt == carrier_high_len) begin
                phase_cnt <= 6'h00;
                carrier   <= 1'b0;
            end else if (!carrier && phase_cnt == carrier_low_len) begin
                phase_cnt <= 6'h00;
                carrier   <= 1'b1;
            end else begin
                phase_cnt <= phase_cnt + 6'h01;
            end
        end
    end

    // Transmit pin driven from a flop
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ir_output_pin <= 1'b0;
        end else begin
            ir_output_pin <= tx_mode && pulse_level_bit && carrier;
        end
    end

    // Configuration and carrier registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg.car_div      <= irr_pkg::DIV_RESET;
            cfg.len_div      <= irr_pkg::DIV_RESET;
            cfg.dir          <= irr_pkg::IRR_DIR_TX;
            cfg.enable       <= 1'b0;
            carrier_low_len  <= irr_pkg::PHASE_RESET;
            carrier_high_len <= irr_pkg::PHASE_RESET;
        end else if (wr && addr == irr_pkg::ADDR_CONFIG) begin
            cfg.car_div <= wdata[irr_pkg::CFG_CAR_DIV_LSB +: 4];
            cfg.len_div <= wdata[irr_pkg::CFG_LEN_DIV_LSB +: 4];
            cfg.dir     <= irr_pkg::irr_dir_t'(wdata[irr_pkg::CFG_DIR_BIT]);
            cfg.enable  <= wdata[irr_pkg::CFG_EN_BIT];
        end else if (wr && addr == irr_pkg::ADDR_CARRIER) begin
            carrier_low_len  <= wdata[irr_pkg::CAR_LOW_LSB +: 6];
            carrier_high_len <= wdata[irr_pkg::CAR_HIGH_LSB +: 6];
        end
    end

    // Data length counter; a write restarts it, zero holds
    assign count_run = pulse_length_count != irr_pkg::COUNT_RESET;
    assign ufl_evt   = active && len_tick
                       && pulse_length_count == 8'h01;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pulse_length_count <= irr_pkg::COUNT_RESET;
        end else if (wr && addr == irr_pkg::ADDR_LENGTH) begin
            pulse_length_count <= wdata[irr_pkg::LEN_COUNT_LSB +: 8];
        end else if (active && len_tick && count_run) begin
            pulse_length_count <= pulse_length_count - 8'h01;
        end
    end

    // Level bit: software-written in transmit, follows input in receive
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pulse_level_bit <= 1'b0;
        end else if (rx_mode) begin
            pulse_level_bit <= rx_level;
        end else if (wr && addr == irr_pkg::ADDR_LENGTH) begin
            pulse_level_bit <= wdata[irr_pkg::LEN_LEVEL_BIT];
        end
    end

    // Interrupt enables
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_en <= 3'b000;
        end else if (wr && addr == irr_pkg::ADDR_INTERRUPT) begin
            irq_en.fall <= wdata[irr_pkg::INT_FALL_EN];
            irq_en.rise <= wdata[irr_pkg::INT_RISE_EN];
            irq_en.ufl  <= wdata[irr_pkg::INT_UFL_EN];
        end
    end

    // Sticky flags; a new event wins over a same-cycle clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flags <= 3'b000;
        end else begin
            if (ufl_evt) begin
                flags.ufl <= 1'b1;
            end else if (wr && addr == irr_pkg::ADDR_INTERRUPT
                         && wdata[irr_pkg::INT_UFL_FLAG]) begin
                flags.ufl <= 1'b0;
            end
            if (rise_evt) begin
                flags.rise <= 1'b1;
            end else if (wr && addr == irr_pkg::ADDR_INTERRUPT
                         && wdata[irr_pkg::INT_RISE_FLAG]) begin
                flags.rise <= 1'b0;
            end
            if (fall_evt) begin
                flags.fall <= 1'b1;
            end else if (wr && addr == irr_pkg::ADDR_INTERRUPT
                         && wdata[irr_pkg::INT_FALL_FLAG]) begin
                flags.fall <= 1'b0;
            end
        end
    end

    // Registered interrupt, one cycle after the flag
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flags & irq_en);
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 16'h0000;
        end else if (!rd) begin
            rdata <= 16'h0000;
        end else begin
            case (addr)
                irr_pkg::ADDR_CONFIG:
                    rdata <= {cfg.car_div, cfg.len_div, 6'h00,
                              cfg.dir, cfg.enable};
                irr_pkg::ADDR_CARRIER:
                    rdata <= {2'h0, carrier_low_len, 2'h0, carrier_high_len};
                irr_pkg::ADDR_LENGTH:
                    rdata <= {pulse_length_count, 7'h00, pulse_level_bit};
                irr_pkg::ADDR_INTERRUPT:
                    rdata <= {5'h00, flags, 5'h00, irq_en};
                default:
                    rdata <= 16'h0000;
            endcase
        end
    end

    a_irq_gating: assert property (@(posedge clk) disable iff (!rstn)
        ##1 irq == $past(|(flags & irq_en)))
        else $error("irq does not follow enabled flags");

    a_ufl_masked: assert property (@(posedge clk) disable iff (!rstn)
        (flags == 3'b001 && !irq_en.ufl) |=> !irq)
        else $error("masked underflow reached irq");

    a_rise_masked: assert property (@(posedge clk) disable iff (!rstn)
        (flags == 3'b010 && !irq_en.rise) |=> !irq)
        else $error("masked rising edge reached irq");

    a_fall_masked: assert property (@(posedge clk) disable iff (!rstn)
        (flags == 3'b100 && !irq_en.fall) |=> !irq)
        else $error("masked falling edge reached irq");

    a_ufl_sets: assert property (@(posedge clk) disable iff (!rstn)
        (ufl_evt && !(wr && addr == irr_pkg::ADDR_LENGTH))
            |=> flags.ufl && pulse_length_count == 8'h00)
        else $error("underflow did not set flag");

    a_count_holds: assert property (@(posedge clk) disable iff (!rstn)
        (pulse_length_count == 8'h00 && !wr) |=> pulse_length_count == 8'h00)
        else $error("counter wrapped");

    a_count_load: assert property (@(posedge clk) disable iff (!rstn)
        (wr && addr == irr_pkg::ADDR_LENGTH)
            |=> pulse_length_count == $past(wdata[15:8]))
        else $error("counter not loaded");

    a_flag_clear: assert property (@(posedge clk) disable iff (!rstn)
        (wr && addr == irr_pkg::ADDR_INTERRUPT && wdata[9] && !rise_evt)
            |=> !flags.rise)
        else $error("rise flag not cleared");

    a_pin_idle: assert property (@(posedge clk) disable iff (!rstn)
        (!tx_mode || !pulse_level_bit) |=> !ir_output_pin)
        else $error("output pin active while idle");

    a_rise_sets: assert property (@(posedge clk) disable iff (!rstn)
        rise_evt |=> flags.rise && rx_level)
        else $error("rise flag not set");

    a_fall_sets: assert property (@(posedge clk) disable iff (!rstn)
        fall_evt |=> flags.fall && !rx_level)
        else $error("fall flag not set");

    a_read_config: assert property (@(posedge clk) disable iff (!rstn)
        (rd && addr == irr_pkg::ADDR_CONFIG)
            |=> rdata[1:0] == $past({cfg.dir, cfg.enable}))
        else $error("config readback wrong");
endmodule // irr_unit

// file: tb/irr_partner.sv
// Behavioural model of the receiver module and the LED at the far side
`timescale 1ns/100ps
module irr_partner (
    // Clock
    input  wire logic clk,
    // Infrared pins
    input  wire logic ir_output_pin,
    output logic      ir_input_pin
);
    int   pulse_count = 0;
    logic led_q       = 1'b0;

    // Receiver output idles high with no light, like a real module
    initial begin
        ir_input_pin = 1'b1;
    end

    // Counts light bursts so a silent LED can be seen
    always @(posedge clk) begin
        led_q <= ir_output_pin;
        if (ir_output_pin && !led_q) begin
            pulse_count <= pulse_count + 1;
        end
    end

    // Holds a level for cycles plus one clocks; short runs make a glitch
    task automatic drive(input logic level, input int cycles);
        @(posedge clk);
        ir_input_pin <= level;
        repeat (cycles) @(posedge clk);
    endtask
endmodule // irr_partner

// file: tb/tb.sv
// Self-checking testbench for the infrared remote unit
`timescale 1ns/100ps
module tb;
    logic        clk;
    logic        rstn;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        ir_input_pin;
    logic        ir_output_pin;
    logic        irq;
    int          failures        = 0;
    int          samples_checked = 0;
    int          cyc             = 0;
    int          t0              = 0;

    // Edge count for timing the length counter
    always @(posedge clk) begin
        cyc <= cyc + 1;
    end

    irr_unit dut (
        .clk           (clk),
        .rstn          (rstn),
        .addr          (addr),
        .wdata         (wdata),
        .wr            (wr),
        .rd            (rd),
        .rdata         (rdata),
        .ir_input_pin  (ir_input_pin),
        .ir_output_pin (ir_output_pin),
        .irq           (irq)
    );

    irr_partner far_end (
        .clk           (clk),
        .ir_output_pin (ir_output_pin),
        .ir_input_pin  (ir_input_pin)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_sim();
        if (failures == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp,
                         input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Reserved bits are always written as zero by these tests
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        check("rdata", exp, rdata);
    endtask

    task automatic chk_irq(input logic exp);
        check("irq", {15'h0, exp}, {15'h0, irq});
    endtask

    // Bounded walk to a rising pin edge, then times one high and one low run
    task automatic carrier_runs(input logic [15:0] eh, input logic [15:0] el);
        int n;
        int hi;
        int lo;
        n  = 0;
        hi = 0;
        lo = 0;
        while (ir_output_pin !== 1'b0 && n < 300) begin idle(1); n++; end
        while (ir_output_pin !== 1'b1 && n < 300) begin idle(1); n++; end
        while (ir_output_pin === 1'b1 && n < 300) begin idle(1); n++; hi++; end
        while (ir_output_pin === 1'b0 && n < 300) begin idle(1); n++; lo++; end
        check("carrier_high", eh, hi[15:0]);
        check("carrier_low", el, lo[15:0]);
    endtask

    // Silent LED over a span: no pin level and no new bursts
    task automatic pin_quiet();
        int   p;
        logic seen;
        p    = far_end.pulse_count;
        seen = 1'b0;
        repeat (30) begin idle(1); seen = seen | ir_output_pin; end
        check("pin_idle", 16'h0000, {15'h0, seen});
        check("pulses", p[15:0], far_end.pulse_count[15:0]);
    endtask

    initial begin
        #100000;
        failures++;
        end_sim();
    end

    initial begin
        rstn  = 1'b0;
        addr  = 16'h0000;
        wdata = 16'h0000;
        wr    = 1'b0;
        rd    = 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        // Reset values, map and an unmapped place
        rd_reg(irr_pkg::ADDR_CONFIG, 16'h0000);
        rd_reg(irr_pkg::ADDR_CARRIER, 16'h0000);
        rd_reg(irr_pkg::ADDR_LENGTH, 16'h0000);
        rd_reg(irr_pkg::ADDR_INTERRUPT, 16'h0000);
        rd_reg(16'h5348, 16'h0000);
        chk_irq(1'b0);
        wr_reg(irr_pkg::ADDR_CARRIER, 16'h3F3F);
        rd_reg(irr_pkg::ADDR_CARRIER, 16'h3F3F);
        wr_reg(16'h5348, 16'h0000);
        rd_reg(irr_pkg::ADDR_CARRIER, 16'h3F3F);
        // Transmit, level one: high 2+1, low 1+1 carrier cycles
        wr_reg(irr_pkg::ADDR_CARRIER, 16'h0102);
        wr_reg(irr_pkg::ADDR_LENGTH, 16'h0001);
        wr_reg(irr_pkg::ADDR_CONFIG, 16'h0001);
        carrier_runs(16'd3, 16'd2);
        // Divider changed only while stopped; carrier at half rate
        wr_reg(irr_pkg::ADDR_CONFIG, 16'h0000);
        wr_reg(irr_pkg::ADDR_CONFIG, 16'h1000);
        wr_reg(irr_pkg::ADDR_CONFIG, 16'h1001);
        carrier_runs(16'd6, 16'd4);
        // Count 4 at one eighth rate: underflow between 24 and 32 cycles
        wr_reg(irr_pkg::ADDR_CONFIG, 16'h0000);
        wr_reg(irr_pkg::ADDR_CONFIG, 16'h0301);
        wr_reg(irr_pkg::ADDR_LENGTH, 16'h0401);
        idle(18);
        rd_reg(irr_pkg::ADDR_INTERRUPT, 16'h0000);
        idle(30);
        rd_reg(irr_pkg::ADDR_INTERRUPT, 16'h0100);
        chk_irq(1'b0);
        rd_reg(irr_pkg::ADDR_LENGTH, 16'h0001);
        idle(40);
        rd_reg(irr_pkg::ADDR_LENGTH, 16'h0001);
        wr_reg(irr_pkg::ADDR_INTERRUPT, 16'h0001);
        rd_reg(irr_pkg::ADDR_INTERRUPT, 16'h0101);
        chk_irq(1'b1);
        wr_reg(irr_pkg::ADDR_INTERRUPT, 16'h0101);
        rd_reg(irr_pkg::ADDR_INTERRUPT, 16'h0001);
        chk_irq(1'b0);
        // Level zero: no carrier; loading zero gives no underflow
        wr_reg(irr_pkg::ADDR_LENGTH, 16'h0000);
        idle(3);
        pin_quiet();
        rd_reg(irr_pkg::ADDR_INTERRUPT, 16'h0001);
        // Receive at half carrier rate so a short pulse meets one sample
        wr_reg(irr_pkg::ADDR_CONFIG, 16'h1002);
        wr_reg(irr_pkg::ADDR_CONFIG, 16'h1003);
        idle(20);
        wr_reg(irr_pkg::ADDR_INTERRUPT, 16'h0706);
        rd_reg(irr_pkg::ADDR_INTERRUPT, 16'h0006);
        pin_quiet();
        far_end.drive(1'b0, 20);
        rd_reg(irr_pkg::ADDR_INTERRUPT, 16'h0406);
        chk_irq(1'b1);
        rd_reg(irr_pkg::ADDR_LENGTH, 16'h0000);
        wr_reg(irr_pkg::ADDR_INTERRUPT, 16'h0406);
        far_end.drive(1'b1, 1);
        far_end.drive(1'b0, 20);
        rd_reg(irr_pkg::ADDR_INTERRUPT, 16'h0006);
        chk_irq(1'b0);
        // Edge flags still record with their enables off
        wr_reg(irr_pkg::ADDR_INTERRUPT, 16'h0004);
        far_end.drive(1'b1, 20);
        rd_reg(irr_pkg::ADDR_INTERRUPT, 16'h0204);
        chk_irq(1'b0);
        rd_reg(irr_pkg::ADDR_LENGTH, 16'h0001);
        wr_reg(irr_pkg::ADDR_LENGTH, 16'hFF00);
        t0 = cyc;
        wr_reg(irr_pkg::ADDR_INTERRUPT, 16'h0202);
        far_end.drive(1'b0, 20);
        t0 = cyc - t0 + 3;
        rd_reg(irr_pkg::ADDR_INTERRUPT, 16'h0402);
        chk_irq(1'b0);
        rd_reg(irr_pkg::ADDR_LENGTH, {8'hFF - 8'(t0), 8'h00});
        // Stopped unit sees no edges
        wr_reg(irr_pkg::ADDR_CONFIG, 16'h0002);
        wr_reg(irr_pkg::ADDR_INTERRUPT, 16'h0700);
        far_end.drive(1'b1, 20);
        rd_reg(irr_pkg::ADDR_INTERRUPT, 16'h0000);
        end_sim();
    end
endmodule // tb
